// [bms_pkg.sv]
`default_nettype none

package bms_pkg;

	// ----------------------------------------
	// Boot actions
	// ----------------------------------------
	typedef enum logic [2:0] {
		BMS_PARALLEL,
		BMS_OTP_JUMP,
		BMS_RAM_JUMP,
		BMS_CAN_LOAD,
		BMS_I2C_LOAD,
		BMS_SPI_LOAD,
		BMS_SERIAL_LOAD,
		BMS_FLASH_JUMP
	} bms_mode_t;

	typedef enum logic [1:0] {
		BMS_ST_RESET,
		BMS_ST_SETTLE,
		BMS_ST_LOCKED
	} bms_state_t;

	// ----------------------------------------
	// Addresses and constants
	// ----------------------------------------
	localparam logic [21:0] BMS_FLASH_ENTRY = 22'h3F7FF6;
	localparam logic [21:0] BMS_OTP_ENTRY   = 22'h3D7800;
	localparam logic [21:0] BMS_RAM_ENTRY   = 22'h000000;
	localparam logic [6:0]  BMS_I2C_ADDR    = 7'h50;
	localparam logic [4:0]  BMS_CAN_MAILBOX = 5'h01;
	localparam logic [4:0]  BMS_PAR_LSB     = 5'h00;
	localparam logic [4:0]  BMS_PAR_MSB     = 5'h0F;
	localparam int          BMS_SYNC_STAGES = 2;
	localparam logic [2:0]  BMS_STRAP_RESET = 3'h0;
	localparam logic [21:0] BMS_ADDR_RESET  = 22'h000000;
	localparam logic [4:0]  BMS_EN_RESET    = 5'h00;
	localparam int          BMS_LOADER_COUNT = 5;
	// Capture waits until the last synchroniser stage holds strap levels sampled after release.
	localparam logic [1:0]  BMS_SETTLE_RESET = 2'h0;
	localparam logic [1:0]  BMS_SETTLE_LAST  = 2'(BMS_SYNC_STAGES - 1);

endpackage

`default_nettype wire

// [bms_sync.sv]
`default_nettype none

module bms_sync
	import bms_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Asynchronous strap levels in, synchronised out
	input  wire logic [2:0] async_in,
	output logic      [2:0] sync_out
);

	logic [2:0] stage_reg [BMS_SYNC_STAGES];
	logic [2:0] stage_next [BMS_SYNC_STAGES];

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	always_comb begin
		stage_next[0] = async_in;
		for (int i = 1; i < BMS_SYNC_STAGES; i++) begin
			stage_next[i] = stage_reg[i-1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BMS_SYNC_STAGES; i++) begin
				stage_reg[i] <= BMS_STRAP_RESET;
			end
		end else begin
			for (int i = 0; i < BMS_SYNC_STAGES; i++) begin
				stage_reg[i] <= stage_next[i];
			end
		end
	end

	assign sync_out = stage_reg[BMS_SYNC_STAGES-1];

endmodule

`default_nettype wire

// [bms_boot_mode_select.sv]
`default_nettype none

module bms_boot_mode_select
	import bms_pkg::*;
(
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// Strap pins
	input  wire logic        BOOT_STRAP_A,
	input  wire logic        BOOT_STRAP_B,
	input  wire logic        BOOT_STRAP_C,
	// Decoded selection
	output logic             MODE_VALID,
	output logic      [2:0]  BOOT_MODE,
	output logic             JUMP_BOOT,
	output logic      [21:0] ENTRY_ADDR,
	// Loader source enables
	output logic             SERIAL_PORT_A_EN,
	output logic             SPI_EEPROM_EN,
	output logic             I2C_EEPROM_EN,
	output logic      [6:0]  I2C_DEV_ADDR,
	output logic             CAN_CONTROLLER_A_EN,
	output logic      [4:0]  CAN_MAILBOX,
	output logic             PARALLEL_BOOT_EN,
	output logic      [4:0]  PARALLEL_PIN_LSB,
	output logic      [4:0]  PARALLEL_PIN_MSB
);

	// ----------------------------------------
	// Strap synchronisation
	// ----------------------------------------
	logic [2:0] strap_sync;

	bms_sync u_sync (
		.clk      (SYS_CLK),
		.rst      (RST),
		.async_in ({BOOT_STRAP_A, BOOT_STRAP_B, BOOT_STRAP_C}),
		.sync_out (strap_sync)
	);

	// Strap a is the most significant bit, so the code equals the mode.
	function automatic bms_mode_t decode_straps(input logic [2:0] s);
		decode_straps = bms_mode_t'(s);
	endfunction

	// Maps a loader enable index to the boot action that selects it.
	function automatic bms_mode_t loader_mode(input int unsigned idx);
		case (idx)
			0:       loader_mode = BMS_SERIAL_LOAD;
			1:       loader_mode = BMS_SPI_LOAD;
			2:       loader_mode = BMS_I2C_LOAD;
			3:       loader_mode = BMS_CAN_LOAD;
			default: loader_mode = BMS_PARALLEL;
		endcase
	endfunction

	// ----------------------------------------
	// Capture sequencing
	// ----------------------------------------
	bms_state_t state_reg;
	bms_state_t state_next;
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	logic       capture;

	// The synchroniser is cleared by reset, so its last stage holds real strap
	// levels only once every stage has been clocked after release. Capturing
	// any earlier would lock in the cleared value and always pick parallel boot.
	always_comb begin
		state_next  = state_reg;
		settle_next = settle_reg;
		capture     = 1'b0;
		case (state_reg)
			BMS_ST_RESET: begin
				state_next  = BMS_ST_SETTLE;
				settle_next = BMS_SETTLE_RESET;
			end
			BMS_ST_SETTLE: begin
				if (settle_reg == BMS_SETTLE_LAST) begin
					state_next = BMS_ST_LOCKED;
					capture    = 1'b1;
				end else begin
					settle_next = settle_reg + 2'h1;
				end
			end
			default: begin
				state_next = BMS_ST_LOCKED;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_reg  <= BMS_ST_RESET;
			settle_reg <= BMS_SETTLE_RESET;
		end else begin
			state_reg  <= state_next;
			settle_reg <= settle_next;
		end
	end

	// ----------------------------------------
	// Boot selection
	// ----------------------------------------
	bms_mode_t   mode_reg;
	bms_mode_t   mode_next;
	logic        jump_reg;
	logic        jump_next;
	logic [21:0] addr_reg;
	logic [21:0] addr_next;
	bms_mode_t   decoded;

	assign decoded = decode_straps(strap_sync);

	// Later pin activity is ignored because the strap pins serve as ordinary
	// I/O once the device is running.
	always_comb begin
		mode_next = mode_reg;
		jump_next = jump_reg;
		addr_next = addr_reg;
		if (capture) begin
			mode_next = decoded;
			jump_next = 1'b0;
			addr_next = BMS_ADDR_RESET;
			case (decoded)
				BMS_FLASH_JUMP: begin
					jump_next = 1'b1;
					addr_next = BMS_FLASH_ENTRY;
				end
				BMS_RAM_JUMP: begin
					jump_next = 1'b1;
					addr_next = BMS_RAM_ENTRY;
				end
				BMS_OTP_JUMP: begin
					jump_next = 1'b1;
					addr_next = BMS_OTP_ENTRY;
				end
				default: begin
					jump_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			mode_reg <= BMS_PARALLEL;
			jump_reg <= 1'b0;
			addr_reg <= BMS_ADDR_RESET;
		end else begin
			mode_reg <= mode_next;
			jump_reg <= jump_next;
			addr_reg <= addr_next;
		end
	end

	// ----------------------------------------
	// Loader enables
	// ----------------------------------------
	logic [4:0] en_reg;
	logic [4:0] en_next;

	// Each index maps to a distinct boot action, so at most one flag is set.
	for (genvar g = 0; g < BMS_LOADER_COUNT; g++) begin : g_loader
		always_comb begin
			en_next[g] = en_reg[g];
			if (capture) begin
				en_next[g] = (decoded == loader_mode(g));
			end
		end

		always_ff @(posedge SYS_CLK or posedge RST) begin
			if (RST) begin
				en_reg[g] <= BMS_EN_RESET[g];
			end else begin
				en_reg[g] <= en_next[g];
			end
		end
	end

	// ----------------------------------------
	// Loader parameters
	// ----------------------------------------
	logic [6:0] i2c_addr_reg;
	logic [6:0] i2c_addr_next;
	logic [4:0] mailbox_reg;
	logic [4:0] mailbox_next;
	logic [4:0] pin_lsb_reg;
	logic [4:0] pin_lsb_next;
	logic [4:0] pin_msb_reg;
	logic [4:0] pin_msb_next;

	// These values are fixed by the boot actions; they still leave the block
	// from flops so that every data output has the same registered timing.
	always_comb begin
		i2c_addr_next = BMS_I2C_ADDR;
		mailbox_next  = BMS_CAN_MAILBOX;
		pin_lsb_next  = BMS_PAR_LSB;
		pin_msb_next  = BMS_PAR_MSB;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			i2c_addr_reg <= BMS_I2C_ADDR;
			mailbox_reg  <= BMS_CAN_MAILBOX;
			pin_lsb_reg  <= BMS_PAR_LSB;
			pin_msb_reg  <= BMS_PAR_MSB;
		end else begin
			i2c_addr_reg <= i2c_addr_next;
			mailbox_reg  <= mailbox_next;
			pin_lsb_reg  <= pin_lsb_next;
			pin_msb_reg  <= pin_msb_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign MODE_VALID          = (state_reg == BMS_ST_LOCKED);
	assign BOOT_MODE           = mode_reg;
	assign JUMP_BOOT           = jump_reg;
	assign ENTRY_ADDR          = addr_reg;
	assign SERIAL_PORT_A_EN    = en_reg[0];
	assign SPI_EEPROM_EN       = en_reg[1];
	assign I2C_EEPROM_EN       = en_reg[2];
	assign I2C_DEV_ADDR        = i2c_addr_reg;
	assign CAN_CONTROLLER_A_EN = en_reg[3];
	assign CAN_MAILBOX         = mailbox_reg;
	assign PARALLEL_BOOT_EN    = en_reg[4];
	assign PARALLEL_PIN_LSB    = pin_lsb_reg;
	assign PARALLEL_PIN_MSB    = pin_msb_reg;

endmodule

`default_nettype wire

// [bms_props.sv]
`default_nettype none

module bms_props
	import bms_pkg::*;
(
	// Clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RST,
	// Observed selection
	input wire logic        MODE_VALID,
	input wire logic [2:0]  BOOT_MODE,
	input wire logic        JUMP_BOOT,
	input wire logic [21:0] ENTRY_ADDR,
	input wire logic        SERIAL_PORT_A_EN,
	input wire logic        SPI_EEPROM_EN,
	input wire logic        I2C_EEPROM_EN,
	input wire logic        CAN_CONTROLLER_A_EN,
	input wire logic        PARALLEL_BOOT_EN
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	AST_HOLD: assert property (MODE_VALID |=> MODE_VALID && $stable(BOOT_MODE) && $stable(ENTRY_ADDR))
		else $error("selection moved");
	AST_JUMP: assert property (MODE_VALID |-> JUMP_BOOT == (BOOT_MODE inside {3'h7, 3'h2, 3'h1}))
		else $error("jump flag wrong");
	AST_FLASH: assert property (MODE_VALID && BOOT_MODE == 3'h7 |-> ENTRY_ADDR == 22'h3F7FF6)
		else $error("flash entry wrong");
	AST_OTP: assert property (MODE_VALID && BOOT_MODE == 3'h1 |-> ENTRY_ADDR == 22'h3D7800)
		else $error("otp entry wrong");
	AST_RAM: assert property (MODE_VALID && BOOT_MODE == 3'h2 |-> ENTRY_ADDR == 22'h000000)
		else $error("ram entry wrong");
	AST_IDLE: assert property (!MODE_VALID |-> !JUMP_BOOT && ENTRY_ADDR == 22'h000000 && !SERIAL_PORT_A_EN
		&& !SPI_EEPROM_EN && !I2C_EEPROM_EN && !CAN_CONTROLLER_A_EN && !PARALLEL_BOOT_EN)
		else $error("selection shown before capture");
	AST_SERIAL: assert property (MODE_VALID |-> SERIAL_PORT_A_EN == (BOOT_MODE == 3'h6))
		else $error("serial enable wrong");
	AST_SPI: assert property (MODE_VALID |-> SPI_EEPROM_EN == (BOOT_MODE == 3'h5))
		else $error("spi enable wrong");
	AST_I2C: assert property (MODE_VALID |-> I2C_EEPROM_EN == (BOOT_MODE == 3'h4))
		else $error("i2c enable wrong");
	AST_CAN: assert property (MODE_VALID |-> CAN_CONTROLLER_A_EN == (BOOT_MODE == 3'h3))
		else $error("can enable wrong");
	AST_PAR: assert property (MODE_VALID |-> PARALLEL_BOOT_EN == (BOOT_MODE == 3'h0))
		else $error("parallel enable wrong");
endmodule

`default_nettype wire

// [bms_strap_model.sv]
`default_nettype none

module bms_strap_model (
	// Wanted boot code
	input  wire logic [2:0] code,
	// Strap pins
	output logic            strap_a,
	output logic            strap_b,
	output logic            strap_c
);
	timeunit 1ns;
	timeprecision 1ns;
	// Board straps are static levels, so the loader traffic itself is left out.
	assign {strap_a, strap_b, strap_c} = code;
endmodule

`default_nettype wire

// [tb_top.sv]
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  code = 3'h0;
	logic        sa, sb, sc, valid, jump, ser, spi, i2c, can, par;
	logic [2:0]  mode;
	logic [21:0] addr;
	logic [6:0]  i2ca;
	logic [4:0]  mbox, plsb, pmsb;
	int          failures = 0;
	int          comparisons = 0;
	always #10 clk = ~clk;
	bms_strap_model u_straps (.code(code), .strap_a(sa), .strap_b(sb), .strap_c(sc));
	bms_boot_mode_select u_dut (.SYS_CLK(clk), .RST(rst), .BOOT_STRAP_A(sa), .BOOT_STRAP_B(sb),
		.BOOT_STRAP_C(sc), .MODE_VALID(valid), .BOOT_MODE(mode), .JUMP_BOOT(jump), .ENTRY_ADDR(addr),
		.SERIAL_PORT_A_EN(ser), .SPI_EEPROM_EN(spi), .I2C_EEPROM_EN(i2c), .I2C_DEV_ADDR(i2ca),
		.CAN_CONTROLLER_A_EN(can), .CAN_MAILBOX(mbox), .PARALLEL_BOOT_EN(par),
		.PARALLEL_PIN_LSB(plsb), .PARALLEL_PIN_MSB(pmsb));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Straps settle well before release so the synchroniser latency cannot hide them.
	task automatic boot_case(input logic [2:0] c);
		logic [21:0] want;
		int          n;
		want = (c == 3'h7) ? 22'h3F7FF6 : (c == 3'h1) ? 22'h3D7800 : 22'h000000;
		rst = 1'b1;
		code = c;
		repeat (4) @(negedge clk);
		check({valid, jump, addr, ser, spi, i2c, can, par}, 32'h0);
		rst = 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		if (valid !== 1'b1) begin
			failures++;
			complete_run();
		end
		check(mode, c);
		check(jump, c inside {3'h7, 3'h2, 3'h1});
		check(addr, want);
		check({ser, spi, i2c, can, par}, {c == 3'h6, c == 3'h5, c == 3'h4, c == 3'h3, c == 3'h0});
		check({i2ca, mbox, plsb, pmsb}, {7'h50, 5'h01, 5'h00, 5'h0F});
		code = ~c;
		repeat (6) @(negedge clk);
		check({valid, mode, addr}, {1'b1, c, want});
	endtask
	initial begin
		repeat (20) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			boot_case(3'(i));
		end
		complete_run();
	end
endmodule

bind bms_boot_mode_select bms_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .MODE_VALID(MODE_VALID),
	.BOOT_MODE(BOOT_MODE), .JUMP_BOOT(JUMP_BOOT), .ENTRY_ADDR(ENTRY_ADDR), .SERIAL_PORT_A_EN(SERIAL_PORT_A_EN),
	.SPI_EEPROM_EN(SPI_EEPROM_EN), .I2C_EEPROM_EN(I2C_EEPROM_EN), .CAN_CONTROLLER_A_EN(CAN_CONTROLLER_A_EN),
	.PARALLEL_BOOT_EN(PARALLEL_BOOT_EN));

`default_nettype wire
